// *** hw/slpaf_consts.svh ***
// Named constants of the speech analysis front end.
`ifndef SLPAF_CONSTS_SVH
`define SLPAF_CONSTS_SVH
`define SLPAF_LAST_IDX 8'h9F
`define SLPAF_SEG1_END 8'h0C
`define SLPAF_SEG2_END 8'h1A
`define SLPAF_SEG3_END 8'h27
`define SLPAF_LAST_LAG 4'h8
`define SLPAF_ORDER 4'h8
`define SLPAF_NCOEF 8
`define SLPAF_TOP_MAG 30
`define SLPAF_Q 5'h0F
`define SLPAF_HALF_SH 5'h10
`define SLPAF_SH1 3'h1
`define SLPAF_SH2 3'h2
`define SLPAF_IN_SHR 3'h3
`define SLPAF_IN_SHL 3'h2
`define SLPAF_QUANT_SH 4'h9
`define SLPAF_DEC_SH 4'hA
`define SLPAF_MAX16 16'sh7FFF
`define SLPAF_MIN16 16'sh8000
`define SLPAF_ZERO16 16'sh0000
`define SLPAF_MAX16_L 32'sh00007FFF
`define SLPAF_MIN16_L 32'shFFFF8000
`define SLPAF_MAX32 32'sh7FFFFFFF
`define SLPAF_MIN32 32'sh80000000
`define SLPAF_RND_L 32'sh00004000
`define SLPAF_HALF16 16'sh4000
`define SLPAF_HP_COEF 16'sh7FDF
`define SLPAF_PRE_COEF 16'sh91EC
`define SLPAF_AUTO_BASE 6'sh04
`define SLPAF_QUANT_RND 16'sh0100
`define SLPAF_LAR_T1 16'sh5666
`define SLPAF_LAR_T2 16'sh799A
`define SLPAF_LAR_C1 16'sh2B33
`define SLPAF_LAR_C2 16'sh6600
`define SLPAF_RP_T2 16'sh4E66
`endif

// *** hw/slpaf_fifo.sv ***
// Small first-in first-out buffer built from flip-flops.
`timescale 1ns/1ns
module slpaf_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Filling and draining sides.
	slpaf_stream_if.snk wr_s,
	slpaf_stream_if.src rd_s
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	assign wr_s.ready = cnt_q != (AW+1)'(DEPTH);
	assign rd_s.valid = cnt_q != '0;
	assign rd_s.data = mem_q[rp_q];
	assign push = wr_s.valid && wr_s.ready;
	assign pop = rd_s.valid && rd_s.ready;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				mem_q[wp_q] <= wr_s.data;
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : AW'(wp_q + 1'b1);
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : AW'(rp_q + 1'b1);
			end
			if (push && !pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop && !push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // slpaf_fifo

// *** hw/slpaf_frontend.sv ***
// Functional notes
// - 160-sample frames in four parts of samples 0-12, 13-26, 27-39 and 40-159, eight codes per frame.
// - Input word shifts right by three, then left by two.
// - Saturated difference to previous input, which is then replaced.
// - Recursive state updates by split high and low multiply by 32735.
// - High-pass output is state plus 16384, saturated, shifted right 15.
// - Both offset states persist across frames and reset to zero.
// - Pre-emphasis adds rounded product of previous sample and -28180.
// - Scale is zero for zero peak, else four minus peak normalisation.
// - Positive scale multiplies samples by 16384 shifted right scale-1.
// - Nine lag sums accumulate saturated doubled products.
// - Recursion arrays load from normalised correlations first.
// - Stop with remaining coefficients zero when P0 below abs of P1.
// - Fractional division, negated for positive P1; at most eight steps.
// - Coefficient magnitude maps piecewise to area ratio, sign restored.
// - Quantise by slope, offset, rounding, shift, clamp, minus minimum.
// - Decode: add minimum, shift, remove offset, inverse slope, double.
// - First three sample ranges mix previous and current decoded sets; the fourth takes current.
// - Previous decoded set is kept for the next frame, zero at reset.
// - Interpolated ratio maps back to coefficient, sign restored.
// - Eight lattice stages per sample give the residual.
// - Lattice state words persist across frames and reset to zero.
// - Sixteen and thirty-two bit sums saturate at their limits.
// - Rounded and plain fractional multiply; min squared gives max.
// - Long multiply returns full product doubled.
`timescale 1ns/1ns
`include "slpaf_consts.svh"
module slpaf_frontend #(
	parameter logic [8*16-1:0] SLOPE_TBL = {8{16'h4000}},
	parameter logic [8*16-1:0] OFFSET_TBL = {8{16'h0000}},
	parameter logic [8*16-1:0] RATIO_CODE_MIN_TBL = {8{16'hFFE0}},
	parameter logic [8*16-1:0] RATIO_CODE_MAX_TBL = {8{16'h001F}},
	parameter logic [8*16-1:0] INVERSE_SLOPE_TBL = {8{16'h4000}},
	parameter int CODE_W = 6,
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Sample input stream.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [15:0] in_data,
	// Residual output stream.
	output logic out_valid,
	input wire logic out_ready,
	output logic [15:0] out_residual,
	// Coded area ratios of each frame.
	output logic codes_valid,
	output logic [8*CODE_W-1:0] coded_area_ratio
);
	function automatic slpaf_pkg::slpaf_w16_t sat16(input logic signed [31:0] x);
		if (x > `SLPAF_MAX16_L) begin
			return `SLPAF_MAX16;
		end else if (x < `SLPAF_MIN16_L) begin
			return `SLPAF_MIN16;
		end
		return x[15:0];
	endfunction
	function automatic slpaf_pkg::slpaf_w16_t add16(input logic signed [15:0] a,
			input logic signed [15:0] b);
		return sat16(32'(a) + 32'(b));
	endfunction
	function automatic slpaf_pkg::slpaf_w16_t sub16(input logic signed [15:0] a,
			input logic signed [15:0] b);
		return sat16(32'(a) - 32'(b));
	endfunction
	function automatic slpaf_pkg::slpaf_w16_t mulr(input logic signed [15:0] a,
			input logic signed [15:0] b);
		logic signed [31:0] p;
		p = 32'(a) * 32'(b) + `SLPAF_RND_L;
		if (a == `SLPAF_MIN16 && b == `SLPAF_MIN16) begin
			return `SLPAF_MAX16;
		end
		return 16'(p >>> `SLPAF_Q);
	endfunction
	function automatic slpaf_pkg::slpaf_w16_t mul(input logic signed [15:0] a,
			input logic signed [15:0] b);
		logic signed [31:0] p;
		p = 32'(a) * 32'(b);
		if (a == `SLPAF_MIN16 && b == `SLPAF_MIN16) begin
			return `SLPAF_MAX16;
		end
		return 16'(p >>> `SLPAF_Q);
	endfunction
	function automatic slpaf_pkg::slpaf_w32_t lmul(input logic signed [15:0] a,
			input logic signed [15:0] b);
		return (32'(a) * 32'(b)) <<< `SLPAF_SH1;
	endfunction
	function automatic slpaf_pkg::slpaf_w32_t ladd(input logic signed [31:0] a,
			input logic signed [31:0] b);
		logic signed [32:0] s;
		s = 33'(a) + 33'(b);
		if (s[32] != s[31]) begin
			return s[32] ? `SLPAF_MIN32 : `SLPAF_MAX32;
		end
		return s[31:0];
	endfunction
	function automatic slpaf_pkg::slpaf_w16_t abs16(input logic signed [15:0] a);
		if (a == `SLPAF_MIN16) begin
			return `SLPAF_MAX16;
		end
		return (a < 0) ? -a : a;
	endfunction
	// Left shifts that bring a positive word's top one under the sign bit.
	function automatic logic [4:0] norm32(input logic [31:0] x);
		int j;
		logic hit;
		norm32 = 5'h00;
		hit = 1'b0;
		for (j = `SLPAF_TOP_MAG; j >= 0; j--) begin
			if (!hit && x[j]) begin
				hit = 1'b1;
			end else if (!hit) begin
				norm32 = 5'(norm32 + 5'h01);
			end
		end
	endfunction
	// Fractional division by restoring subtraction, with num not above den.
	function automatic slpaf_pkg::slpaf_w16_t div15(input logic signed [15:0] num,
			input logic signed [15:0] den);
		logic [15:0] q;
		logic [31:0] ln;
		logic [31:0] ld;
		int j;
		q = 16'h0000;
		ln = 32'(num);
		ld = 32'(den);
		for (j = 0; j < 15; j++) begin
			q = q << 1;
			ln = ln << 1;
			if (ln >= ld) begin
				ln = ln - ld;
				q = q + 16'h0001;
			end
		end
		return q;
	endfunction

	slpaf_pkg::slpaf_state_e st_q;
	logic [7:0] idx_q;
	logic [3:0] lag_q;
	logic [3:0] n_q;
	slpaf_pkg::slpaf_w16_t sbuf_q [0:`SLPAF_LAST_IDX];
	slpaf_pkg::slpaf_w16_t offset_prev_input_q;
	slpaf_pkg::slpaf_w32_t offset_recursive_state_q;
	slpaf_pkg::slpaf_w16_t preemph_prev_sample_q;
	slpaf_pkg::slpaf_w16_t smax_q;
	slpaf_pkg::slpaf_w32_t acc_q;
	slpaf_pkg::slpaf_w32_t autocorr_sum_q [0:8];
	slpaf_pkg::slpaf_w16_t p_q [0:8];
	slpaf_pkg::slpaf_w16_t k_q [2:8];
	slpaf_pkg::slpaf_w16_t r_q [1:8];
	slpaf_pkg::slpaf_w16_t coded_area_ratio_q [1:8];
	slpaf_pkg::slpaf_w16_t decoded_area_ratio_q [1:8];
	slpaf_pkg::slpaf_w16_t decoded_prev_q [1:8];
	slpaf_pkg::slpaf_w16_t u_q [0:7];
	slpaf_pkg::slpaf_w16_t out_q;
	logic out_valid_q;
	logic codes_valid_q;

	slpaf_stream_if #(.W(16)) in_if ();
	slpaf_stream_if #(.W(16)) q_if ();

	slpaf_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.wr_s(in_if),
		.rd_s(q_if)
	);

	assign in_if.valid = in_valid;
	assign in_if.data = in_data;
	assign in_ready = in_if.ready;
	assign q_if.ready = st_q == slpaf_pkg::ST_COLLECT;

	// Per-sample pre-processing of the word leaving the buffer.
	logic take_w;
	slpaf_pkg::slpaf_w16_t fd_w;
	slpaf_pkg::slpaf_w16_t so_w;
	slpaf_pkg::slpaf_w16_t s1_w;
	slpaf_pkg::slpaf_w16_t msp_w;
	slpaf_pkg::slpaf_w16_t lsp_w;
	slpaf_pkg::slpaf_w32_t ls2_w;
	slpaf_pkg::slpaf_w32_t lz2_d;
	slpaf_pkg::slpaf_w16_t sof_w;
	slpaf_pkg::slpaf_w16_t pre_w;
	assign take_w = q_if.valid && q_if.ready;
	assign fd_w = q_if.data;
	assign so_w = (fd_w >>> `SLPAF_IN_SHR) <<< `SLPAF_IN_SHL;
	assign s1_w = sub16(so_w, offset_prev_input_q);
	assign msp_w = 16'(offset_recursive_state_q >>> `SLPAF_Q);
	assign lsp_w = 16'(offset_recursive_state_q - (32'(msp_w) <<< `SLPAF_Q));
	assign ls2_w = ladd(32'(s1_w) <<< `SLPAF_Q,
		32'(mulr(lsp_w, `SLPAF_HP_COEF)));
	assign lz2_d = ladd(lmul(msp_w, `SLPAF_HP_COEF) >>> `SLPAF_SH1,
		ls2_w);
	assign sof_w = 16'(ladd(lz2_d, `SLPAF_RND_L) >>> `SLPAF_Q);
	assign pre_w = add16(sof_w, mulr(preemph_prev_sample_q,
		`SLPAF_PRE_COEF));

	// Dynamic scaling and correlation datapath.
	logic signed [5:0] scal_w;
	logic scal_pos;
	slpaf_pkg::slpaf_w16_t stemp_w;
	slpaf_pkg::slpaf_w16_t sa_w;
	slpaf_pkg::slpaf_w16_t sb_w;
	slpaf_pkg::slpaf_w16_t ra_w;
	slpaf_pkg::slpaf_w16_t rb_w;
	slpaf_pkg::slpaf_w32_t acc_d;
	slpaf_pkg::slpaf_w16_t fin_w;
	assign scal_w = (smax_q == `SLPAF_ZERO16) ? 6'sh00 :
		`SLPAF_AUTO_BASE - $signed({1'b0, norm32({smax_q, 16'h0000})});
	assign scal_pos = scal_w > 6'sh00;
	assign stemp_w = `SLPAF_HALF16 >>> 3'(scal_w - 6'sh01);
	assign ra_w = sbuf_q[idx_q];
	assign rb_w = sbuf_q[8'(idx_q - 8'(lag_q))];
	assign sa_w = scal_pos ? mulr(ra_w, stemp_w) : ra_w;
	assign sb_w = scal_pos ? mulr(rb_w, stemp_w) : rb_w;
	assign acc_d = ladd(acc_q, lmul(sa_w, sb_w));
	assign fin_w = scal_pos ? sa_w <<< scal_w[2:0] : sa_w;

	// Normalisation and one recursion step.
	logic [4:0] nrm_w;
	slpaf_pkg::slpaf_w16_t acn_w [0:8];
	slpaf_pkg::slpaf_w16_t p1abs_w;
	logic stop_w;
	slpaf_pkg::slpaf_w16_t rdiv_w;
	slpaf_pkg::slpaf_w16_t rn_w;
	slpaf_pkg::slpaf_w16_t pn_w [0:8];
	slpaf_pkg::slpaf_w16_t kn_w [2:8];
	assign nrm_w = norm32(autocorr_sum_q[0]);
	assign p1abs_w = abs16(p_q[1]);
	assign stop_w = p_q[0] < p1abs_w;
	assign rdiv_w = div15(p1abs_w, p_q[0]);
	assign rn_w = (p_q[1] > 0) ? sub16(`SLPAF_ZERO16, rdiv_w) : rdiv_w;
	assign pn_w[0] = add16(p_q[0], mulr(p_q[1], rn_w));
	assign pn_w[8] = p_q[8];
	genvar gj;
	generate
		for (gj = 0; gj <= `SLPAF_NCOEF; gj++) begin : g_norm
			assign acn_w[gj] = 16'((autocorr_sum_q[gj] <<< nrm_w) >>>
				`SLPAF_HALF_SH);
		end
		for (gj = 1; gj < `SLPAF_NCOEF; gj++) begin : g_schur
			logic act;
			assign act = 4'(gj) <= 4'(`SLPAF_ORDER - n_q);
			assign pn_w[gj] = act ? add16(p_q[gj+1],
				mulr(k_q[`SLPAF_NCOEF+1-gj], rn_w)) : p_q[gj];
			assign kn_w[`SLPAF_NCOEF+1-gj] = act ?
				add16(k_q[`SLPAF_NCOEF+1-gj],
				mulr(p_q[gj+1], rn_w)) : k_q[`SLPAF_NCOEF+1-gj];
		end
	endgenerate

	// Area ratios, codes, decoding, interpolation and lattice per index.
	logic seg1_w;
	logic seg2_w;
	logic seg3_w;
	slpaf_pkg::slpaf_w16_t code_w [1:8];
	slpaf_pkg::slpaf_w16_t dec_w [1:8];
	slpaf_pkg::slpaf_w16_t di_w [0:8];
	slpaf_pkg::slpaf_w16_t sav_w [0:8];
	slpaf_pkg::slpaf_w16_t u_d [0:7];
	assign seg1_w = idx_q <= `SLPAF_SEG1_END;
	assign seg2_w = !seg1_w && idx_q <= `SLPAF_SEG2_END;
	assign seg3_w = !seg1_w && !seg2_w && idx_q <= `SLPAF_SEG3_END;
	assign di_w[0] = fin_w;
	assign sav_w[0] = fin_w;
	genvar gi;
	generate
		for (gi = 1; gi <= `SLPAF_NCOEF; gi++) begin : g_idx
			slpaf_pkg::slpaf_w16_t slope;
			slpaf_pkg::slpaf_w16_t offs;
			slpaf_pkg::slpaf_w16_t ratio_code_min;
			slpaf_pkg::slpaf_w16_t ratio_code_max;
			slpaf_pkg::slpaf_w16_t inverse_slope;
			slpaf_pkg::slpaf_w16_t ra;
			slpaf_pkg::slpaf_w16_t lmag;
			slpaf_pkg::slpaf_w16_t area_ratio;
			slpaf_pkg::slpaf_w16_t qv;
			slpaf_pkg::slpaf_w16_t qc;
			slpaf_pkg::slpaf_w16_t t1;
			slpaf_pkg::slpaf_w16_t t2;
			slpaf_pkg::slpaf_w16_t pv;
			slpaf_pkg::slpaf_w16_t cv;
			slpaf_pkg::slpaf_w16_t mix;
			slpaf_pkg::slpaf_w16_t interp_area_ratio;
			slpaf_pkg::slpaf_w16_t ia;
			slpaf_pkg::slpaf_w16_t rm;
			slpaf_pkg::slpaf_w16_t quant_reflection_coef;
			assign slope = SLOPE_TBL[16*(gi-1) +: 16];
			assign offs = OFFSET_TBL[16*(gi-1) +: 16];
			assign ratio_code_min = RATIO_CODE_MIN_TBL[16*(gi-1) +: 16];
			assign ratio_code_max = RATIO_CODE_MAX_TBL[16*(gi-1) +: 16];
			assign inverse_slope = INVERSE_SLOPE_TBL[16*(gi-1) +: 16];
			assign ra = abs16(r_q[gi]);
			assign lmag = (ra < `SLPAF_LAR_T1) ? ra >>> `SLPAF_SH1 :
				(ra < `SLPAF_LAR_T2) ? sub16(ra, `SLPAF_LAR_C1) :
				sub16(ra, `SLPAF_LAR_C2) <<< `SLPAF_SH2;
			assign area_ratio = (r_q[gi] < 0) ?
				sub16(`SLPAF_ZERO16, lmag) : lmag;
			assign qv = add16(add16(mul(slope, area_ratio), offs),
				`SLPAF_QUANT_RND) >>> `SLPAF_QUANT_SH;
			assign qc = (qv > ratio_code_max) ? ratio_code_max :
				(qv < ratio_code_min) ? ratio_code_min : qv;
			assign code_w[gi] = sub16(qc, ratio_code_min);
			assign t1 = sub16(add16(code_w[gi], ratio_code_min) <<<
				`SLPAF_DEC_SH, offs <<< `SLPAF_SH1);
			assign t2 = mulr(inverse_slope, t1);
			assign dec_w[gi] = add16(t2, t2);
			assign pv = decoded_prev_q[gi];
			assign cv = decoded_area_ratio_q[gi];
			assign mix = add16(pv >>> `SLPAF_SH2, cv >>> `SLPAF_SH2);
			assign interp_area_ratio =
				seg1_w ? add16(mix, pv >>> `SLPAF_SH1) :
				seg2_w ? add16(pv >>> `SLPAF_SH1, cv >>> `SLPAF_SH1) :
				seg3_w ? add16(mix, cv >>> `SLPAF_SH1) : cv;
			assign ia = abs16(interp_area_ratio);
			assign rm = (ia < `SLPAF_LAR_C1) ? ia <<< `SLPAF_SH1 :
				(ia < `SLPAF_RP_T2) ? add16(ia, `SLPAF_LAR_C1) :
				add16(ia >>> `SLPAF_SH2, `SLPAF_LAR_C2);
			assign quant_reflection_coef = (interp_area_ratio < 0) ?
				sub16(`SLPAF_ZERO16, rm) : rm;
			assign sav_w[gi] = add16(u_q[gi-1],
				mulr(quant_reflection_coef, di_w[gi-1]));
			assign di_w[gi] = add16(di_w[gi-1],
				mulr(quant_reflection_coef, u_q[gi-1]));
			assign u_d[gi-1] = sav_w[gi-1];
			assign coded_area_ratio[CODE_W*(gi-1) +: CODE_W] =
				coded_area_ratio_q[gi][CODE_W-1:0];
		end
	endgenerate

	logic emit_w;
	assign emit_w = st_q == slpaf_pkg::ST_FILT && (!out_valid_q || out_ready);
	assign out_valid = out_valid_q;
	assign out_residual = out_q;
	assign codes_valid = codes_valid_q;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_valid_q <= 1'b0;
			out_q <= `SLPAF_ZERO16;
		end else if (emit_w) begin
			out_valid_q <= 1'b1;
			out_q <= di_w[`SLPAF_NCOEF];
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_q <= slpaf_pkg::ST_COLLECT;
			idx_q <= 8'h00;
			lag_q <= 4'h0;
			n_q <= 4'h1;
			acc_q <= '0;
			smax_q <= `SLPAF_ZERO16;
			codes_valid_q <= 1'b0;
			offset_prev_input_q <= `SLPAF_ZERO16;
			offset_recursive_state_q <= '0;
			preemph_prev_sample_q <= `SLPAF_ZERO16;
			autocorr_sum_q <= '{default: '0};
			p_q <= '{default: '0};
			k_q <= '{default: '0};
			r_q <= '{default: '0};
			coded_area_ratio_q <= '{default: '0};
			decoded_area_ratio_q <= '{default: '0};
			decoded_prev_q <= '{default: '0};
			u_q <= '{default: '0};
		end else begin
			codes_valid_q <= 1'b0;
			case (st_q)
				slpaf_pkg::ST_COLLECT: begin
					if (take_w) begin
						sbuf_q[idx_q] <= pre_w;
						offset_prev_input_q <= so_w;
						offset_recursive_state_q <= lz2_d;
						preemph_prev_sample_q <= sof_w;
						if (abs16(pre_w) > smax_q) begin
							smax_q <= abs16(pre_w);
						end
						if (idx_q == `SLPAF_LAST_IDX) begin
							idx_q <= 8'h00;
							lag_q <= 4'h0;
							acc_q <= '0;
							st_q <= slpaf_pkg::ST_ACF;
						end else begin
							idx_q <= 8'(idx_q + 8'h01);
						end
					end
				end
				slpaf_pkg::ST_ACF: begin
					if (idx_q == `SLPAF_LAST_IDX) begin
						autocorr_sum_q[lag_q] <= acc_d;
						acc_q <= '0;
						if (lag_q == `SLPAF_LAST_LAG) begin
							st_q <= slpaf_pkg::ST_NORM;
						end else begin
							lag_q <= 4'(lag_q + 4'h1);
							idx_q <= 8'(lag_q + 4'h1);
						end
					end else begin
						acc_q <= acc_d;
						idx_q <= 8'(idx_q + 8'h01);
					end
				end
				slpaf_pkg::ST_NORM: begin
					r_q <= '{default: '0};
					n_q <= 4'h1;
					if (autocorr_sum_q[0] == '0) begin
						st_q <= slpaf_pkg::ST_LAR;
					end else begin
						p_q <= acn_w;
						for (int i = 1; i < `SLPAF_NCOEF; i++) begin
							k_q[`SLPAF_NCOEF+1-i] <= acn_w[i];
						end
						st_q <= slpaf_pkg::ST_SCHUR;
					end
				end
				slpaf_pkg::ST_SCHUR: begin
					if (stop_w) begin
						st_q <= slpaf_pkg::ST_LAR;
					end else begin
						r_q[n_q] <= rn_w;
						p_q <= pn_w;
						k_q <= kn_w;
						n_q <= 4'(n_q + 4'h1);
						if (n_q == `SLPAF_ORDER) begin
							st_q <= slpaf_pkg::ST_LAR;
						end
					end
				end
				slpaf_pkg::ST_LAR: begin
					coded_area_ratio_q <= code_w;
					decoded_prev_q <= decoded_area_ratio_q;
					decoded_area_ratio_q <= dec_w;
					codes_valid_q <= 1'b1;
					idx_q <= 8'h00;
					st_q <= slpaf_pkg::ST_FILT;
				end
				slpaf_pkg::ST_FILT: begin
					if (emit_w) begin
						u_q <= u_d;
						if (idx_q == `SLPAF_LAST_IDX) begin
							idx_q <= 8'h00;
							smax_q <= `SLPAF_ZERO16;
							st_q <= slpaf_pkg::ST_COLLECT;
						end else begin
							idx_q <= 8'(idx_q + 8'h01);
						end
					end
				end
				default: begin
					st_q <= slpaf_pkg::ST_COLLECT;
				end
			endcase
		end
	end
endmodule // slpaf_frontend

// *** hw/slpaf_pkg.sv ***
// Types shared by the speech analysis front end.
package slpaf_pkg;
	typedef enum logic [5:0] {
		ST_COLLECT = 6'h01,
		ST_ACF = 6'h02,
		ST_NORM = 6'h04,
		ST_SCHUR = 6'h08,
		ST_LAR = 6'h10,
		ST_FILT = 6'h20
	} slpaf_state_e;
	typedef logic signed [15:0] slpaf_w16_t;
	typedef logic signed [31:0] slpaf_w32_t;
endpackage

// *** hw/slpaf_stream_if.sv ***
// Valid and ready word stream between the front end's modules.
`timescale 1ns/1ns
interface slpaf_stream_if #(parameter int W = 16) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// *** sim/slpaf_frontend_monitor.sv ***
// Concurrent checks on the front end's ports.
`timescale 1ns/1ns
module slpaf_frontend_monitor #(parameter int CODE_W = 6) (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Streams.
	input wire logic in_valid,
	input wire logic in_ready,
	input wire logic [15:0] in_data,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [15:0] out_residual,
	// Codes.
	input wire logic codes_valid,
	input wire logic [8*CODE_W-1:0] coded_area_ratio
);
	int out_cnt;
	int gap;
	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_cnt <= 160;
			gap <= 0;
		end else begin
			if (codes_valid) begin
				out_cnt <= out_cnt - 160 + int'(out_valid && out_ready);
			end else if (out_valid && out_ready) begin
				out_cnt <= out_cnt + 1;
			end
			if (codes_valid) begin
				gap <= 0;
			end else if (gap < 5000) begin
				gap <= gap + 1;
			end
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_stall;
		out_valid && !out_ready;
	endsequence
	sequence s_frame_done;
		out_cnt == 160 || (out_cnt == 159 && out_valid);
	endsequence
	chk_reset_clear: assert property ($past(rst) |->
		!out_valid && !codes_valid && coded_area_ratio == '0 && in_ready)
		else $error("outputs not clear after reset");
	chk_codes_pulse: assert property (codes_valid |=> !codes_valid)
		else $error("codes pulse too long");
	chk_codes_held: assert property (!codes_valid |->
		$stable(coded_area_ratio))
		else $error("codes changed without pulse");
	chk_residual_hold: assert property (s_stall |=>
		out_valid && $stable(out_residual))
		else $error("residual dropped while stalled");
	chk_frame_whole: assert property (codes_valid |-> s_frame_done)
		else $error("frame residuals incomplete");
	chk_frame_length: assert property (out_valid && out_ready |->
		out_cnt < 160)
		else $error("too many residuals");
	chk_acf_time: assert property (codes_valid |-> gap >= 1500)
		else $error("codes came too early");
	chk_fill_refuse: assert property ($fell(in_ready) |->
		$past(in_valid && in_ready))
		else $error("ready fell without a take");
endmodule // slpaf_frontend_monitor
bind slpaf_frontend slpaf_frontend_monitor #(.CODE_W(CODE_W)) i_mon (
	.core_clk(core_clk),
	.rst(rst),
	.in_valid(in_valid),
	.in_ready(in_ready),
	.in_data(in_data),
	.out_valid(out_valid),
	.out_ready(out_ready),
	.out_residual(out_residual),
	.codes_valid(codes_valid),
	.coded_area_ratio(coded_area_ratio)
);

// *** sim/slpaf_sample_source.sv ***
// Sample source model that offers one frame of words on request.
`timescale 1ns/1ns
module slpaf_sample_source (
	// Clock and reset.
	input wire logic core_clk,
	input wire logic rst,
	// Frame request.
	input wire logic start,
	input wire logic [15:0] first_word,
	input wire logic [15:0] fill_word,
	// Sample stream.
	output logic in_valid,
	input wire logic in_ready,
	output logic [15:0] in_data
);
	int left = 0;
	logic taken = 1'b0;
	logic armed = 1'b0;
	initial begin
		in_valid = 1'b0;
		in_data = 16'h0000;
	end
	always @(posedge core_clk) begin
		taken <= in_valid && in_ready;
		armed <= start;
	end
	// Words are held until taken; idle data toggles every cycle.
	always @(negedge core_clk) begin
		if (rst) begin
			in_valid <= 1'b0;
			left <= 0;
		end else if (in_valid && taken) begin
			left <= left - 1;
			in_valid <= (left > 1);
			in_data <= (left > 1) ? fill_word : ~in_data;
		end else if (!in_valid && armed) begin
			in_valid <= 1'b1;
			in_data <= first_word;
			left <= 160;
		end else if (!in_valid) begin
			in_data <= ~in_data;
		end
	end
endmodule // slpaf_sample_source

// *** sim/speech_lpc_analysis_frontend_bench.sv ***
// Self-checking bench of the speech analysis front end.
`timescale 1ns/1ns
module speech_lpc_analysis_frontend_bench;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic out_ready = 1'b0;
	logic [15:0] first_word = 16'h0000;
	logic [15:0] fill_word = 16'h0000;
	logic in_valid, in_ready, out_valid, codes_valid;
	logic [15:0] in_data, out_residual;
	logic [15:0] res0 = 16'h0000;
	logic [15:0] res_or = 16'h0000;
	logic [47:0] codes_seen, coded_area_ratio;
	int n_res = 0;
	int n_codes = 0;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	slpaf_frontend i_dut (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_data),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_residual(out_residual),
		.codes_valid(codes_valid),
		.coded_area_ratio(coded_area_ratio)
	);
	slpaf_sample_source i_src (
		.core_clk(core_clk),
		.rst(rst),
		.start(start),
		.first_word(first_word),
		.fill_word(fill_word),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_data)
	);
	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if ((out_valid === 1'b1) && out_ready) begin
			if (n_res % 160 == 0) res0 <= out_residual;
			res_or <= res_or | out_residual;
			n_res <= n_res + 1;
		end
		if (codes_valid === 1'b1) begin
			n_codes <= n_codes + 1;
			codes_seen <= coded_area_ratio;
		end
		if (cyc == 20000) begin
			n_errors = n_errors + 1;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (20) @(negedge core_clk);
		rst = 1'b0;
	endtask
	task automatic send_frame(input logic [15:0] w0, input logic [15:0] w);
		@(negedge core_clk);
		first_word = w0;
		fill_word = w;
		start = 1'b1;
		@(negedge core_clk);
		start = 1'b0;
	endtask
	// Two frames of spare-bit noise, the second refused while stalled.
	task automatic test_zero_frames();
		int c;
		c = n_codes;
		send_frame(16'h0007, 16'h0007);
		for (int i = 0; i < 3000 && n_codes == c; i++) @(negedge core_clk);
		send_frame(16'h0007, 16'h0007);
		repeat (30) @(negedge core_clk);
		chk("in_ready stalled", 48'h0, {47'h0, in_ready});
		out_ready = 1'b1;
		for (int i = 0; i < 5000 && n_res < 320; i++) @(negedge core_clk);
		chk("residual count", 48'h140, 48'(n_res));
		chk("code pulses", 48'h2, 48'(n_codes - c));
		chk("zero codes", {8{6'h20}}, codes_seen);
		chk("zero residuals", 48'h0, {32'h0, res_or});
	endtask
	// First residual after reset equals the cleaned, rescaled input word.
	task automatic test_first_sample(input logic [15:0] w, input logic [15:0] exp);
		int c;
		do_reset();
		c = n_res;
		send_frame(w, 16'h0000);
		for (int i = 0; i < 3000 && n_res < c + 160; i++) @(negedge core_clk);
		chk("frame residuals", 48'hA0, 48'(n_res - c));
		chk("first residual", {32'h0, exp}, {32'h0, res0});
	endtask
	initial begin
		do_reset();
		test_zero_frames();
		test_first_sample(16'h0205, 16'h0100);
		test_first_sample(16'hFE07, 16'hFF00);
		test_first_sample(16'h7FF8, 16'h4000);
		stop_test();
	end
endmodule // speech_lpc_analysis_frontend_bench
